/* File: src/fpt_pkg.sv */
package fpt_pkg;

	// Operations accepted from the pipeline.
	typedef enum logic [4:0] {
		OP_SETF_S, OP_SETF_D, OP_SETF_EXP, OP_SETF_SIG,
		OP_GETF_S, OP_GETF_D, OP_GETF_EXP, OP_GETF_SIG,
		OP_LDF_S, OP_LDF_D, OP_STF_S, OP_STF_D,
		OP_FMA, OP_FMS, OP_FNMA, OP_FMPY, OP_FNMPY, OP_FADD, OP_FSUB,
		OP_FNORM, OP_FCVT_XUF, OP_SIGNED_TO_FLOAT_CONVERT, OP_ARITH_NOPC, OP_NOP
	} fpt_op_e;

	// Fused multiply-add flavour that the execution unit performs.
	typedef enum logic [1:0] {FK_NONE, FK_ADD, FK_SUB, FK_NADD} fpt_fma_e;

	// Static precision completer.
	localparam logic [1:0] PC_NONE = 2'h0;
	localparam logic [1:0] PC_SGL = 2'h1;
	localparam logic [1:0] PC_DBL = 2'h2;

	// Result significand precision codes.
	localparam logic [1:0] PREC_24 = 2'h0;
	localparam logic [1:0] PREC_53 = 2'h1;
	localparam logic [1:0] PREC_64 = 2'h2;

	// Result exponent range codes.
	localparam logic [1:0] RNG_8 = 2'h0;
	localparam logic [1:0] RNG_11 = 2'h1;
	localparam logic [1:0] RNG_15 = 2'h2;
	localparam logic [1:0] RNG_17 = 2'h3;

	// Dynamic precision-control field values.
	localparam logic [1:0] DPC_SGL = 2'h0;
	localparam logic [1:0] DPC_RSVD = 2'h1;
	localparam logic [1:0] DPC_DBL = 2'h2;

	// Field positions inside one 7-bit status field control group.
	localparam int CTL_W = 7;
	localparam int CTL_FTZ = 0;
	localparam int CTL_WRE = 1;
	localparam int CTL_PC_LO = 2;
	localparam int CTL_RC_LO = 4;
	localparam int CTL_TD = 6;
	localparam int TRAP_W = 6;

	// Register-format constants.
	localparam logic [16:0] EXP_INT = 17'h1_003E;
	localparam logic [16:0] EXP_FP_DEFERRED_EXCEPTION_VALUE = 17'h1_FFFE;
	localparam logic [16:0] EXP_MAX = 17'h1_FFFF;
	localparam logic [16:0] EXP_SGL_ADJ = 17'h0_FF80;
	localparam logic [16:0] EXP_DBL_ADJ = 17'h0_FC00;
	localparam logic [63:0] SIG_ONE = 64'h8000_0000_0000_0000;
	localparam int EXP_SIGN_POS = 17;

	// Fixed floating register indices used by the derived operations.
	localparam logic [6:0] FR_ZERO = 7'h00;
	localparam logic [6:0] FR_ONE = 7'h01;

endpackage

/* File: src/fpt_fmt_conv.sv */
`timescale 1ns/1ns
// Translates single/double memory words to register format and back.
module fpt_fmt_conv (
	input wire logic dbl,
	input wire logic [63:0] mem_in,
	output logic ld_sign,
	output logic [16:0] ld_exp,
	output logic [63:0] ld_sig,
	input wire logic st_sign,
	input wire logic [16:0] st_exp,
	input wire logic [63:0] st_sig,
	output logic [63:0] mem_out
);

	logic [10:0] e_in;
	logic [51:0] f_in;
	logic [10:0] e_out;
	logic [16:0] adj;

	// Memory word to register format; denormals get the minimum exponent.
	always_comb begin
		adj = dbl ? fpt_pkg::EXP_DBL_ADJ : fpt_pkg::EXP_SGL_ADJ;
		e_in = dbl ? mem_in[62:52] : {3'h0, mem_in[30:23]};
		f_in = dbl ? mem_in[51:0] : {mem_in[22:0], 29'h0};
		ld_sign = dbl ? mem_in[63] : mem_in[31];
		ld_sig = {1'b1, f_in, 11'h0};
		if (e_in == (dbl ? 11'h7FF : 11'h0FF)) begin
			ld_exp = fpt_pkg::EXP_MAX;
		end else if (e_in == 11'h0) begin
			ld_sig = {1'b0, f_in, 11'h0};
			ld_exp = (f_in == 52'h0) ? 17'h0 : adj + 17'h1;
		end else begin
			ld_exp = {6'h0, e_in} + adj;
		end
	end

	// Register format to memory word; a clear integer bit marks a denormal.
	always_comb begin
		if (st_exp == fpt_pkg::EXP_MAX) begin
			e_out = dbl ? 11'h7FF : 11'h0FF;
		end else if (st_exp == 17'h0 || !st_sig[63]) begin
			e_out = 11'h0;
		end else begin
			e_out = 11'(st_exp - adj);
		end
		if (dbl) begin
			mem_out = {st_sign, e_out, st_sig[62:11]};
		end else begin
			mem_out = {32'h0, st_sign, e_out[7:0], st_sig[62:40]};
		end
	end

endmodule

/* File: src/fpt_xfer_map.sv */
`timescale 1ns/1ns
// Contract
// - Token converts to deferred value and back.
// - Single/double moves use memory representation.
// - Significand set: sign 0, exponent 0x1003E.
// - Exponent set: sign bit 17, exponent bits 16:0.
// - Get of deferred value sets token.
// - Selector picks one of four status fields.
// - Signed convert has no field, always exact.
// - Static completer else dynamic precision control.
// - Range like precision plus widest-range bit.
// - No completer: full register precision, range; with req_par the code gives 24-bit precision, 8-bit range.
// - Multiply is fused add with register 0.
// - Negate-multiply is negated fused add, register 0.
// - Add/subtract use register 1 as multiplicand.
// - Normalize/unsigned convert use registers 1 and 0.
// - Multiply rounds product alone, no addition.
// - Loads/stores support both byte orders.
// - Single/double order like 32/64-bit integers.
// - Trap-disable set treats all traps disabled.
// - Field zero trap-disable reads as zero.
module fpt_xfer_map (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire fpt_pkg::fpt_op_e req_op,
	input wire logic [1:0] req_sf,
	input wire logic [1:0] req_pc,
	input wire logic req_par,
	input wire logic [6:0] req_src_a,
	input wire logic [6:0] req_src_b,
	input wire logic [6:0] req_src_c,
	input wire logic [63:0] gr_in,
	input wire logic gr_nat_in,
	input wire logic fr_sign_in,
	input wire logic [16:0] fr_exp_in,
	input wire logic [63:0] fr_sig_in,
	input wire logic big_endian,
	input wire logic [27:0] sf_ctl,
	input wire logic [5:0] traps,
	output logic res_valid,
	output logic fr_we,
	output logic fr_sign,
	output logic [16:0] fr_exp,
	output logic [63:0] fr_sig,
	output logic gr_we,
	output logic [63:0] gr_val,
	output logic gr_nat,
	output logic nat_fault,
	output logic arith_valid,
	output fpt_pkg::fpt_fma_e fma_kind,
	output logic [6:0] mul_a,
	output logic [6:0] mul_b,
	output logic [6:0] add_c,
	output logic prod_round,
	output logic exact,
	output logic flags_upd,
	output logic [1:0] sf_sel,
	output logic [1:0] rc,
	output logic ftz,
	output logic [1:0] sig_prec,
	output logic [1:0] exp_rng,
	output logic pc_rsvd,
	output logic [5:0] trap_dis,
	output logic [6:0] ctl_rd
);

	typedef struct packed {
		logic res_valid;
		logic fr_we;
		logic fr_sign;
		logic [16:0] fr_exp;
		logic [63:0] fr_sig;
		logic gr_we;
		logic [63:0] gr_val;
		logic gr_nat;
		logic nat_fault;
		logic arith_valid;
		fpt_pkg::fpt_fma_e fma_kind;
		logic [6:0] mul_a;
		logic [6:0] mul_b;
		logic [6:0] add_c;
		logic prod_round;
		logic exact;
		logic flags_upd;
		logic [1:0] sf_sel;
		logic [1:0] rc;
		logic ftz;
		logic [1:0] sig_prec;
		logic [1:0] exp_rng;
		logic pc_rsvd;
		logic [5:0] trap_dis;
		logic [6:0] ctl_rd;
	} fpt_state_s;

	fpt_state_s q;
	fpt_state_s d;
	logic rst_meta_q;
	logic rst_q;
	logic [6:0] ctl;
	logic dbl;
	logic is_ld;
	logic [63:0] cv_in;
	logic cv_sign;
	logic [16:0] cv_exp;
	logic [63:0] cv_sig;
	logic [63:0] cv_mem;
	logic src_fp_deferred_exception_value;
	logic [4:0] prc;

	// Reverses bytes of a 32-bit or 64-bit word when big-endian.
	function automatic logic [63:0] order_bytes(input logic [63:0] w, input logic be,
			input logic wide);
		logic [63:0] r;
		r = w;
		if (be && wide) begin
			for (int i = 0; i < 8; i++) begin
				r[8*i +: 8] = w[8*(7-i) +: 8];
			end
		end else if (be) begin
			for (int i = 0; i < 4; i++) begin
				r[8*i +: 8] = w[8*(3-i) +: 8];
			end
		end
		return r;
	endfunction

	// Returns {reserved, precision, range} for an arithmetic operation.
	function automatic logic [4:0] pick_prec(input logic par, input logic has_pc,
			input logic [1:0] pc, input logic [6:0] c);
		logic [1:0] p;
		logic [1:0] g;
		logic wre;
		logic rsv;
		wre = c[fpt_pkg::CTL_WRE];
		rsv = 1'b0;
		if (!has_pc) begin
			p = par ? fpt_pkg::PREC_24 : fpt_pkg::PREC_64;
			g = par ? fpt_pkg::RNG_8 : fpt_pkg::RNG_17;
		end else if (pc == fpt_pkg::PC_SGL) begin
			p = fpt_pkg::PREC_24;
			g = wre ? fpt_pkg::RNG_17 : fpt_pkg::RNG_8;
		end else if (pc == fpt_pkg::PC_DBL) begin
			p = fpt_pkg::PREC_53;
			g = wre ? fpt_pkg::RNG_17 : fpt_pkg::RNG_11;
		end else begin
			g = wre ? fpt_pkg::RNG_17 : fpt_pkg::RNG_15;
			case (c[fpt_pkg::CTL_PC_LO +: 2])
				fpt_pkg::DPC_SGL: p = fpt_pkg::PREC_24;
				fpt_pkg::DPC_DBL: p = fpt_pkg::PREC_53;
				fpt_pkg::DPC_RSVD: begin
					p = fpt_pkg::PREC_64;
					rsv = 1'b1;
				end
				default: p = fpt_pkg::PREC_64;
			endcase
		end
		return {rsv, p, g};
	endfunction

	// Offset of a status field's control group.
	function automatic int ctl_base(input logic [1:0] s);
		return fpt_pkg::CTL_W * int'(s);
	endfunction

	// Two-stage release of the asynchronous reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	// Memory words pass the byte-order stage; register moves do not.
	always_comb begin
		dbl = req_op inside {fpt_pkg::OP_SETF_D, fpt_pkg::OP_GETF_D, fpt_pkg::OP_LDF_D,
			fpt_pkg::OP_STF_D};
		is_ld = req_op inside {fpt_pkg::OP_LDF_S, fpt_pkg::OP_LDF_D};
		cv_in = is_ld ? order_bytes(gr_in, big_endian, dbl) : gr_in;
		src_fp_deferred_exception_value = !fr_sign_in && fr_exp_in == fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE && fr_sig_in == '0;
		ctl = sf_ctl[ctl_base(req_sf) +: fpt_pkg::CTL_W];
		prc = pick_prec(req_par, req_op != fpt_pkg::OP_ARITH_NOPC, req_pc, ctl);
	end

	fpt_fmt_conv u_conv (
		.dbl(dbl),
		.mem_in(cv_in),
		.ld_sign(cv_sign),
		.ld_exp(cv_exp),
		.ld_sig(cv_sig),
		.st_sign(fr_sign_in),
		.st_exp(fr_exp_in),
		.st_sig(fr_sig_in),
		.mem_out(cv_mem)
	);

	// Next-state: one result per accepted request except OP_NOP, one cycle later.
	always_comb begin
		d = q;
		d.res_valid = req_valid;
		d.fr_we = 1'b0;
		d.gr_we = 1'b0;
		d.nat_fault = 1'b0;
		d.arith_valid = 1'b0;
		if (req_valid) begin
			case (req_op)
				fpt_pkg::OP_SETF_S, fpt_pkg::OP_SETF_D, fpt_pkg::OP_LDF_S,
				fpt_pkg::OP_LDF_D: begin
					d.fr_we = 1'b1;
					d.fr_sign = cv_sign;
					d.fr_exp = cv_exp;
					d.fr_sig = cv_sig;
				end
				fpt_pkg::OP_SETF_SIG: begin
					d.fr_we = 1'b1;
					d.fr_sign = 1'b0;
					d.fr_exp = fpt_pkg::EXP_INT;
					d.fr_sig = gr_in;
				end
				fpt_pkg::OP_SETF_EXP: begin
					d.fr_we = 1'b1;
					d.fr_sign = gr_in[fpt_pkg::EXP_SIGN_POS];
					d.fr_exp = gr_in[16:0];
					d.fr_sig = fpt_pkg::SIG_ONE;
				end
				fpt_pkg::OP_GETF_S, fpt_pkg::OP_GETF_D, fpt_pkg::OP_GETF_SIG: begin
					d.gr_we = 1'b1;
					d.gr_nat = src_fp_deferred_exception_value;
					if (src_fp_deferred_exception_value) begin
						d.gr_val = '0;
					end else if (req_op == fpt_pkg::OP_GETF_SIG) begin
						d.gr_val = fr_sig_in;
					end else begin
						d.gr_val = cv_mem;
					end
				end
				fpt_pkg::OP_GETF_EXP: begin
					d.gr_we = 1'b1;
					d.gr_nat = src_fp_deferred_exception_value;
					d.gr_val = {46'h0, fr_sign_in, fr_exp_in};
				end
				fpt_pkg::OP_STF_S, fpt_pkg::OP_STF_D: begin
					d.nat_fault = src_fp_deferred_exception_value;
					d.gr_we = !src_fp_deferred_exception_value;
					d.gr_nat = 1'b0;
					d.gr_val = order_bytes(cv_mem, big_endian, dbl);
				end
				fpt_pkg::OP_NOP: begin
					d.res_valid = 1'b0;
				end
				default: begin
					d.arith_valid = 1'b1;
					d.fma_kind = fpt_pkg::FK_NONE;
					d.mul_a = req_src_a;
					d.mul_b = req_src_b;
					d.add_c = req_src_c;
					d.prod_round = 1'b0;
					d.exact = 1'b0;
					d.flags_upd = 1'b1;
					d.sf_sel = req_sf;
					d.rc = ctl[fpt_pkg::CTL_RC_LO +: 2];
					d.ftz = ctl[fpt_pkg::CTL_FTZ];
					{d.pc_rsvd, d.sig_prec, d.exp_rng} = prc;
					if (ctl[fpt_pkg::CTL_TD] && req_sf != 2'h0) begin
						d.trap_dis = '1;
					end else begin
						d.trap_dis = traps;
					end
					d.ctl_rd = ctl;
					if (req_sf == 2'h0) begin
						d.ctl_rd[fpt_pkg::CTL_TD] = 1'b0;
					end
					case (req_op)
						fpt_pkg::OP_FMA: d.fma_kind = fpt_pkg::FK_ADD;
						fpt_pkg::OP_FMS: d.fma_kind = fpt_pkg::FK_SUB;
						fpt_pkg::OP_FNMA: d.fma_kind = fpt_pkg::FK_NADD;
						fpt_pkg::OP_FMPY, fpt_pkg::OP_FNMPY: begin
							d.fma_kind = (req_op == fpt_pkg::OP_FMPY) ?
								fpt_pkg::FK_ADD : fpt_pkg::FK_NADD;
							d.add_c = fpt_pkg::FR_ZERO;
							d.prod_round = 1'b1;
						end
						fpt_pkg::OP_FADD, fpt_pkg::OP_FSUB: begin
							d.fma_kind = (req_op == fpt_pkg::OP_FADD) ?
								fpt_pkg::FK_ADD : fpt_pkg::FK_SUB;
							d.mul_b = fpt_pkg::FR_ONE;
							d.add_c = req_src_b;
						end
						fpt_pkg::OP_FNORM, fpt_pkg::OP_FCVT_XUF: begin
							d.fma_kind = fpt_pkg::FK_ADD;
							d.mul_b = fpt_pkg::FR_ONE;
							d.add_c = fpt_pkg::FR_ZERO;
						end
						fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT: begin
							d.exact = 1'b1;
							d.flags_upd = 1'b0;
							d.trap_dis = '1;
						end
						default: d.fma_kind = fpt_pkg::FK_NONE;
					endcase
				end
			endcase
			// A set integer token on any SETF register move becomes the deferred value.
			if (gr_nat_in && req_op inside {fpt_pkg::OP_SETF_S, fpt_pkg::OP_SETF_D,
					fpt_pkg::OP_SETF_SIG, fpt_pkg::OP_SETF_EXP}) begin
				d.fr_sign = 1'b0;
				d.fr_exp = fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE;
				d.fr_sig = '0;
			end
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state flops.
	assign res_valid = q.res_valid;
	assign fr_we = q.fr_we;
	assign fr_sign = q.fr_sign;
	assign fr_exp = q.fr_exp;
	assign fr_sig = q.fr_sig;
	assign gr_we = q.gr_we;
	assign gr_val = q.gr_val;
	assign gr_nat = q.gr_nat;
	assign nat_fault = q.nat_fault;
	assign arith_valid = q.arith_valid;
	assign fma_kind = q.fma_kind;
	assign mul_a = q.mul_a;
	assign mul_b = q.mul_b;
	assign add_c = q.add_c;
	assign prod_round = q.prod_round;
	assign exact = q.exact;
	assign flags_upd = q.flags_upd;
	assign sf_sel = q.sf_sel;
	assign rc = q.rc;
	assign ftz = q.ftz;
	assign sig_prec = q.sig_prec;
	assign exp_rng = q.exp_rng;
	assign pc_rsvd = q.pc_rsvd;
	assign trap_dis = q.trap_dis;
	assign ctl_rd = q.ctl_rd;

	// Checks on the registered results.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q);

	property p_setf_nat;
		req_valid && gr_nat_in && req_op inside {fpt_pkg::OP_SETF_S, fpt_pkg::OP_SETF_D,
			fpt_pkg::OP_SETF_SIG, fpt_pkg::OP_SETF_EXP} |=>
			fr_we && !fr_sign && fr_exp == fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE && fr_sig == '0;
	endproperty
	a_setf_nat: assert property (p_setf_nat) else $error("token not converted");

	property p_setf_sig;
		req_valid && !gr_nat_in && req_op == fpt_pkg::OP_SETF_SIG |=>
			fr_we && !fr_sign && fr_exp == fpt_pkg::EXP_INT && fr_sig == $past(gr_in);
	endproperty
	a_setf_sig: assert property (p_setf_sig) else $error("sig set wrong");

	property p_setf_exp;
		req_valid && !gr_nat_in && req_op == fpt_pkg::OP_SETF_EXP |=>
			fr_sign == $past(gr_in[17]) && fr_exp == $past(gr_in[16:0]) &&
			fr_sig == fpt_pkg::SIG_ONE;
	endproperty
	a_setf_exp: assert property (p_setf_exp) else $error("exp set wrong");

	property p_getf_nat;
		req_valid && req_op == fpt_pkg::OP_GETF_EXP && src_fp_deferred_exception_value |=>
			gr_nat && gr_val == {47'h0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE};
	endproperty
	a_getf_nat: assert property (p_getf_nat) else $error("token lost");

	property p_mpy;
		req_valid && req_op == fpt_pkg::OP_FMPY |=>
			arith_valid && add_c == fpt_pkg::FR_ZERO && prod_round;
	endproperty
	a_mpy: assert property (p_mpy) else $error("multiply map wrong");

	property p_nmpy;
		req_valid && req_op == fpt_pkg::OP_FNMPY |=> fma_kind == fpt_pkg::FK_NADD;
	endproperty
	a_nmpy: assert property (p_nmpy) else $error("negmul map wrong");

	property p_sub;
		req_valid && req_op == fpt_pkg::OP_FSUB |=>
			fma_kind == fpt_pkg::FK_SUB && mul_b == fpt_pkg::FR_ONE;
	endproperty
	a_sub: assert property (p_sub) else $error("sub map wrong");

	property p_norm;
		req_valid && req_op == fpt_pkg::OP_FNORM |=>
			mul_b == fpt_pkg::FR_ONE && add_c == fpt_pkg::FR_ZERO;
	endproperty
	a_norm: assert property (p_norm) else $error("norm map wrong");

	property p_td;
		req_valid && req_op == fpt_pkg::OP_FMA && req_sf == 2'h0 |=>
			trap_dis == $past(traps) && !ctl_rd[fpt_pkg::CTL_TD];
	endproperty
	a_td: assert property (p_td) else $error("field zero td used");

	property p_nopc;
		req_valid && req_op == fpt_pkg::OP_ARITH_NOPC && !req_par |=>
			sig_prec == fpt_pkg::PREC_64 && exp_rng == fpt_pkg::RNG_17;
	endproperty
	a_nopc: assert property (p_nopc) else $error("full precision lost");

	property p_xf;
		req_valid && req_op == fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT |=> exact && !flags_upd;
	endproperty
	a_xf: assert property (p_xf) else $error("convert not exact");

	c_mpy: cover property (req_valid && req_op == fpt_pkg::OP_FMPY ##1 prod_round);
	c_getf: cover property (req_valid && req_op == fpt_pkg::OP_GETF_SIG ##1 gr_nat);
	c_be: cover property (req_valid && big_endian && req_op == fpt_pkg::OP_LDF_D);

endmodule

/* File: test/fpt_pipe_model.sv */
`timescale 1ns/1ns
// Issue stage of the pipeline: one operation per call, held for exactly one sampling edge.
module fpt_pipe_model (
	input wire logic clk,
	output logic req_valid,
	output fpt_pkg::fpt_op_e req_op,
	output logic [1:0] req_sf,
	output logic [1:0] req_pc,
	output logic req_par
);
	// Idle values from time zero so the strobe is never unknown.
	initial begin
		req_valid = 1'b0;
		req_op = fpt_pkg::OP_NOP;
		req_sf = 2'h0;
		req_pc = 2'h0;
		req_par = 1'b0;
	end

	// Raises the strobe after one edge, drops it after the next, so calls never collide.
	task automatic issue(input fpt_pkg::fpt_op_e op, input logic [1:0] sel,
			input logic [1:0] prc, input logic par);
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_sf <= sel;
		req_pc <= prc;
		req_par <= par;
		@(posedge clk);
		req_valid <= 1'b0;
		req_op <= fpt_pkg::OP_NOP;
	endtask
endmodule

/* File: test/fpt_xfer_map_test.sv */
`timescale 1ns/1ns
// Self-checking bench: stimulus notes each expected result, a watcher compares it.
module fpt_xfer_map_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid, req_par, res_valid, fr_we, fr_sign, gr_we, gr_nat, nat_fault, arith_valid;
	logic prod_round, exact, flags_upd, ftz, pc_rsvd;
	fpt_pkg::fpt_op_e req_op;
	fpt_pkg::fpt_fma_e fma_kind;
	logic [1:0] req_sf, req_pc, sf_sel, rc, sig_prec, exp_rng;
	logic [6:0] req_src_a = 7'h0, req_src_b = 7'h0, req_src_c = 7'h0, mul_a, mul_b, add_c, ctl_rd;
	logic [63:0] gr_in = 64'h0, fr_sig_in = 64'h0, fr_sig, gr_val;
	logic gr_nat_in = 1'b0, fr_sign_in = 1'b0, big_endian = 1'b0;
	logic [16:0] fr_exp_in = 17'h0, fr_exp;
	logic [27:0] sf_ctl = 28'h0;
	logic [5:0] traps = 6'h0, trap_dis;
	int miscompares = 0;
	int cmp_count = 0;
	logic [95:0] exp_q[$];
	logic [95:0] msk_q[$];

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	fpt_pipe_model fpt_pipe_model_inst (.clk, .req_valid, .req_op, .req_sf, .req_pc, .req_par);

	fpt_xfer_map fpt_xfer_map_inst (.clk, .rst_n, .req_valid, .req_op, .req_sf, .req_pc,
		.req_par, .req_src_a, .req_src_b, .req_src_c, .gr_in, .gr_nat_in, .fr_sign_in,
		.fr_exp_in, .fr_sig_in, .big_endian, .sf_ctl, .traps, .res_valid, .fr_we, .fr_sign,
		.fr_exp, .fr_sig, .gr_we, .gr_val, .gr_nat, .nat_fault, .arith_valid, .fma_kind,
		.mul_a, .mul_b, .add_c, .prod_round, .exact, .flags_upd, .sf_sel, .rc, .ftz,
		.sig_prec, .exp_rng, .pc_rsvd, .trap_dis, .ctl_rd);

	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic put(input logic [95:0] e, input logic [95:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
	endtask

	task automatic want_flt(input logic s, input logic [16:0] e, input logic [63:0] g);
		put({2'h1, 12'h0, s, e, g}, '1);
	endtask

	task automatic want_int(input logic n, input logic [63:0] v);
		put({2'h2, 29'h0, n, v}, '1);
	endtask

	task automatic xfer(input fpt_pkg::fpt_op_e op, input logic be, input logic [63:0] g,
			input logic n, input logic s, input logic [16:0] e, input logic [63:0] sig);
		big_endian <= be;
		gr_in <= g;
		gr_nat_in <= n;
		fr_sign_in <= s;
		fr_exp_in <= e;
		fr_sig_in <= sig;
		fpt_pipe_model_inst.issue(op, 2'h0, fpt_pkg::PC_NONE, 1'b0);
	endtask

	// Watcher: packs each result by kind and compares it with the oldest note.
	always @(posedge clk) begin
		logic [95:0] o, e, m;
		if (res_valid === 1'b1) begin
			o = (fr_we === 1'b1) ? {2'h1, 12'h0, fr_sign, fr_exp, fr_sig} :
				(gr_we === 1'b1) ? {2'h2, 29'h0, gr_nat, gr_val} :
				(arith_valid === 1'b1) ? {2'h3, 45'h0, fma_kind, mul_a, mul_b, add_c,
				prod_round, exact, flags_upd, sf_sel, rc, ftz, sig_prec, exp_rng, pc_rsvd,
				trap_dis, ctl_rd} : {95'h0, nat_fault};
			e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
			m = (msk_q.size() != 0) ? msk_q.pop_front() : '1;
			cmp_count++;
			if ((o & m) !== (e & m)) begin
				miscompares++;
				$display("FAIL t=%0t got=%h want=%h", $time, o & m, e & m);
			end
		end
	end

	// Main sequence: reset, transfers, memory images, then arithmetic mapping.
	initial begin
		fpt_pkg::fpt_op_e ao[11];
		fpt_pkg::fpt_op_e op;
		fpt_pkg::fpt_fma_e fk;
		logic [63:0] r, w, u;
		logic [16:0] e17;
		logic [27:0] c28;
		logic [6:0] g, la, lb, lc, mb, ac;
		logic [5:0] t6, tde;
		logic [1:0] sel, prc, sp, er;
		logic par, mp, pp, rsv, xf, pr;
		logic [48:0] ab;
		logic [95:0] mk;
		ao = '{fpt_pkg::OP_FMPY, fpt_pkg::OP_FNMPY, fpt_pkg::OP_FADD, fpt_pkg::OP_FSUB,
			fpt_pkg::OP_FNORM, fpt_pkg::OP_FCVT_XUF, fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT, fpt_pkg::OP_ARITH_NOPC,
			fpt_pkg::OP_FMA, fpt_pkg::OP_FMS, fpt_pkg::OP_FNMA};
		void'($urandom(61502));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			r = {$urandom, $urandom};
			e17 = r[16:0] | 17'h0_0001;
			want_flt(1'b0, fpt_pkg::EXP_INT, r);
			xfer(fpt_pkg::OP_SETF_SIG, 1'b0, r, 1'b0, 1'b0, 17'h0, 64'h0);
			want_flt(r[17], r[16:0], fpt_pkg::SIG_ONE);
			xfer(fpt_pkg::OP_SETF_EXP, 1'b0, r, 1'b0, 1'b0, 17'h0, 64'h0);
			want_int(1'b0, r);
			xfer(fpt_pkg::OP_GETF_SIG, 1'b0, 64'h0, 1'b0, r[63], e17, r);
			want_int(1'b0, {46'h0, r[63], e17});
			xfer(fpt_pkg::OP_GETF_EXP, 1'b0, 64'h0, 1'b0, r[63], e17, r);
		end
		want_flt(1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		xfer(fpt_pkg::OP_SETF_SIG, 1'b0, r, 1'b1, 1'b0, 17'h0, 64'h0);
		want_flt(1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		xfer(fpt_pkg::OP_SETF_EXP, 1'b0, r, 1'b1, 1'b0, 17'h0, 64'h0);
		want_int(1'b1, 64'h0);
		xfer(fpt_pkg::OP_GETF_SIG, 1'b0, 64'h0, 1'b0, 1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		want_int(1'b1, {47'h0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE});
		xfer(fpt_pkg::OP_GETF_EXP, 1'b0, 64'h0, 1'b0, 1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		want_flt(1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		xfer(fpt_pkg::OP_SETF_D, 1'b0, r, 1'b1, 1'b0, 17'h0, 64'h0);
		want_int(1'b1, 64'h0);
		xfer(fpt_pkg::OP_GETF_D, 1'b0, 64'h0, 1'b0, 1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		put({95'h0, 1'b1}, '1);
		xfer(fpt_pkg::OP_STF_D, 1'b0, 64'h0, 1'b0, 1'b0, fpt_pkg::EXP_FP_DEFERRED_EXCEPTION_VALUE, 64'h0);
		for (int k = 0; k < 4; k++) begin
			u = k[1] ? 64'h3FF0_0000_0000_0000 : 64'h0000_0000_3F80_0000;
			w = k[0] ? (k[1] ? 64'h0000_0000_0000_F03F : 64'h0000_0000_0000_803F) : u;
			want_flt(1'b0, 17'h0_FFFF, fpt_pkg::SIG_ONE);
			xfer(k[1] ? fpt_pkg::OP_LDF_D : fpt_pkg::OP_LDF_S, k[0], w, 1'b0, 1'b0, 17'h0, 64'h0);
			want_int(1'b0, w);
			xfer(k[1] ? fpt_pkg::OP_STF_D : fpt_pkg::OP_STF_S, k[0], 64'h0, 1'b0, 1'b0,
				17'h0_FFFF, fpt_pkg::SIG_ONE);
			want_flt(1'b0, 17'h0_FFFF, fpt_pkg::SIG_ONE);
			xfer(k[1] ? fpt_pkg::OP_SETF_D : fpt_pkg::OP_SETF_S, k[0], u, 1'b0, 1'b0, 17'h0, 64'h0);
			want_int(1'b0, u);
			xfer(k[1] ? fpt_pkg::OP_GETF_D : fpt_pkg::OP_GETF_S, k[0], 64'h0, 1'b0, 1'b0,
				17'h0_FFFF, fpt_pkg::SIG_ONE);
		end
		for (int i = 0; i < 66; i++) begin
			op = ao[i % 11];
			sel = (i < 11) ? 2'h0 : 2'($urandom);
			c28 = 28'($urandom);
			t6 = 6'($urandom);
			la = 7'($urandom);
			lb = 7'($urandom);
			lc = 7'($urandom);
			prc = (op == fpt_pkg::OP_ARITH_NOPC) ? fpt_pkg::PC_NONE : 2'(i / 11 % 3);
			par = (op == fpt_pkg::OP_ARITH_NOPC) & 1'($urandom);
			g = 7'(c28 >> (7 * sel));
			fk = fpt_pkg::FK_ADD;
			if (op inside {fpt_pkg::OP_FNMPY, fpt_pkg::OP_FNMA}) begin
				fk = fpt_pkg::FK_NADD;
			end else if (op inside {fpt_pkg::OP_FSUB, fpt_pkg::OP_FMS}) begin
				fk = fpt_pkg::FK_SUB;
			end
			mb = (op inside {fpt_pkg::OP_FMPY, fpt_pkg::OP_FNMPY, fpt_pkg::OP_FMA,
				fpt_pkg::OP_FMS, fpt_pkg::OP_FNMA}) ? lb : fpt_pkg::FR_ONE;
			ac = (op inside {fpt_pkg::OP_FMA, fpt_pkg::OP_FMS, fpt_pkg::OP_FNMA}) ? lc :
				(op inside {fpt_pkg::OP_FADD, fpt_pkg::OP_FSUB}) ? lb : fpt_pkg::FR_ZERO;
			mp = !(op inside {fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT, fpt_pkg::OP_ARITH_NOPC});
			pp = (op != fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT);
			rsv = 1'b0;
			if (op == fpt_pkg::OP_ARITH_NOPC) begin
				{sp, er} = par ? {fpt_pkg::PREC_24, fpt_pkg::RNG_8} : {fpt_pkg::PREC_64, fpt_pkg::RNG_17};
			end else if (prc == fpt_pkg::PC_SGL) begin
				{sp, er} = {fpt_pkg::PREC_24, g[1] ? fpt_pkg::RNG_17 : fpt_pkg::RNG_8};
			end else if (prc == fpt_pkg::PC_DBL) begin
				{sp, er} = {fpt_pkg::PREC_53, g[1] ? fpt_pkg::RNG_17 : fpt_pkg::RNG_11};
			end else begin
				sp = (g[3:2] == fpt_pkg::DPC_SGL) ? fpt_pkg::PREC_24 :
					(g[3:2] == fpt_pkg::DPC_DBL) ? fpt_pkg::PREC_53 : fpt_pkg::PREC_64;
				er = g[1] ? fpt_pkg::RNG_17 : fpt_pkg::RNG_15;
				rsv = (g[3:2] == fpt_pkg::DPC_RSVD);
			end
			tde = (op == fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT || (g[6] && sel != 2'h0)) ? 6'h3F : t6;
			pr = op inside {fpt_pkg::OP_FMPY, fpt_pkg::OP_FNMPY};
			xf = (op == fpt_pkg::OP_SIGNED_TO_FLOAT_CONVERT);
			ab = {fk, la, mb, ac, pr, xf, !xf, sel, g[5:4], g[0], sp, er, rsv, tde,
				(sel == 2'h0) ? {1'b0, g[5:0]} : g};
			mk = {2'h3, 45'h0, {24{mp}}, 2'h3, {10{pp}}, 6'h3F, {7{pp}}};
			put({2'h3, 45'h0, ab}, mk);
			req_src_a <= la;
			req_src_b <= lb;
			req_src_c <= lc;
			sf_ctl <= c28;
			traps <= t6;
			fpt_pipe_model_inst.issue(op, sel, prc, par);
		end
		repeat (4) @(posedge clk);
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("FAIL t=%0t got=%h want=%h", $time, 96'h0, exp_q[0]);
		end
		close_out();
	end
endmodule
